// >>> pbm_fifo_ctrl.sv
// bus-master fifo control: apb registers, two fifos, bus requester
// and dsp pacing interrupts; assumes bus and dsp strobes are on clk
//
// Behaviour
// - host irq at each counter reaching zero
// - reset bits empty the fifo flags
// - read request at one or four vacant
// - write request at one or four filled
// - enable bits start bus requests, set last
// - only host registers enable the master
// - one dsp irq per fifo direction
// - pacing irqs only when dsp enables them
// - pacing enables activate pacing state machine
// - clearing enables idles machine, stops irqs
// - fifos 32 wide, eight deep
// - read irq while read fifo holds data
// - write irq while write fifo not full
`timescale 1ns/1ps
module pbm_fifo_ctrl #(
	parameter int DATA_W = pbm_pkg::DATA_W, // fifo word width
	parameter int DEPTH = pbm_pkg::FIFO_DEPTH // fifo depth in words
) (
	input wire logic clk, // 125 MHz
	input wire logic rst, // synchronous, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [pbm_pkg::ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data, registered
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	output logic busReq, // pci bus request
	input wire logic busGnt, // pci bus grant
	output logic busRead, // 1 = moving host memory into read fifo
	output logic [31:0] busAddr, // current pci address
	input wire logic busRdValid, // host word arrives on busRdData
	input wire logic [DATA_W-1:0] busRdData, // host word
	output logic [DATA_W-1:0] busWrData, // head of write fifo
	input wire logic busWrAccept, // host took busWrData
	output logic hostIrq, // end of transfer irq to host
	input wire logic dspRdEn, // dsp read strobe at fifo address
	output logic [DATA_W-1:0] dspRdData, // word read by dsp
	input wire logic dspWrEn, // dsp write strobe at fifo address
	input wire logic [DATA_W-1:0] dspWrData, // word written by dsp
	output logic read_fifo_dsp_interrupt, // read pacing irq
	output logic write_fifo_dsp_interrupt // write pacing irq
);
	import pbm_pkg::*;
	localparam int CW = $clog2(DEPTH) + 1; // fifo count width
	localparam int PW = $clog2(DEPTH); // fifo pointer width

	logic [31:0] host_interrupt_control_reg; // enables and done flags
	logic [31:0] master_control_status_reg; // stored control bits
	logic [31:0] bus_read_address_reg; // next read address
	logic [31:0] bus_write_address_reg; // next write address
	logic [31:0] write_byte_counter; // bytes left to write
	logic [31:0] read_byte_counter; // bytes left to read
	logic [1:0] pacingEn; // flag register bits 1:0
	logic [31:0] rdMux; // read data selected in setup
	logic addrOk; // address decodes to a register
	logic apbWr; // write takes effect this edge
	pbm_bm_state_t bmState; // bus-master state
	logic lastWasWrite; // round robin between directions
	logic rdMove; // one word into read fifo
	logic wrMove; // one word out of write fifo
	logic [CW-1:0] rdThresh; // selected read threshold
	logic [CW-1:0] wrThresh; // selected write threshold
	logic [CW-1:0] rdVacant; // free words in read fifo
	logic rdWant; // read request condition
	logic wrWant; // write request condition
	// index 0 is the write fifo, index 1 the read fifo
	logic [1:0] fifoPush; // push strobes
	logic [1:0] fifoPop; // pop strobes
	logic [1:0] flush; // flag reset pulses
	logic [DATA_W-1:0] fifoIn [2]; // push data
	logic [DATA_W-1:0] fifoOut [2]; // head words
	logic [CW-1:0] fifoCnt [2]; // fill levels
	logic [1:0] access; // detected dsp fifo access
	logic [1:0] avail; // another word can be moved
	pbm_pace_state_t paceState [2]; // pacing machines
	logic [1:0] paceIrq; // pacing irq levels

	// apb decode: zero wait, access phase always ready
	assign pready = 1'b1;
	assign apbWr = psel && penable && pwrite;
	assign pslverr = psel && penable && !addrOk;

	// register read mux and address check
	always_comb begin
		addrOk = 1'b1;
		rdMux = RST_WORD;
		case (paddr)
			OFF_INTCTL: rdMux = host_interrupt_control_reg;
			OFF_MCTL: rdMux = master_control_status_reg;
			OFF_RDADDR: rdMux = bus_read_address_reg;
			OFF_WRADDR: rdMux = bus_write_address_reg;
			OFF_WRCNT: rdMux = write_byte_counter;
			OFF_RDCNT: rdMux = read_byte_counter;
			OFF_FLAG: begin
				rdMux[FL_WR_PACE] = pacingEn[0];
				rdMux[FL_RD_PACE] = pacingEn[1];
				rdMux[FL_RD_EMPTY] = fifoCnt[1] == '0;
				rdMux[FL_WR_FULL] = fifoCnt[0] == CW'(DEPTH);
				rdMux[FL_RD_IRQ] = paceIrq[1];
				rdMux[FL_WR_IRQ] = paceIrq[0];
			end
			default: addrOk = 1'b0; // unmapped reads zero, errors
		endcase
	end

	// read data captured in the setup cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= RST_WORD;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdMux;
		end
	end

	// host interrupt control: done flags set by hardware win over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			host_interrupt_control_reg <= RST_WORD;
		end else begin
			if (apbWr && paddr == OFF_INTCTL) begin
				host_interrupt_control_reg[IC_WR_DONE_EN] <= pwdata[IC_WR_DONE_EN];
				host_interrupt_control_reg[IC_RD_DONE_EN] <= pwdata[IC_RD_DONE_EN];
				if (pwdata[IC_WR_DONE]) begin
					host_interrupt_control_reg[IC_WR_DONE] <= 1'b0;
				end
				if (pwdata[IC_RD_DONE]) begin
					host_interrupt_control_reg[IC_RD_DONE] <= 1'b0;
				end
			end
			if (wrMove && write_byte_counter == WORD_BYTES) begin
				host_interrupt_control_reg[IC_WR_DONE] <= 1'b1;
			end
			if (rdMove && read_byte_counter == WORD_BYTES) begin
				host_interrupt_control_reg[IC_RD_DONE] <= 1'b1;
			end
		end
	end

	// host irq, each done flag gated by its own enable
	always_ff @(posedge clk) begin
		if (rst) begin
			hostIrq <= 1'b0;
		end else begin
			hostIrq <= (host_interrupt_control_reg[IC_WR_DONE]
				&& host_interrupt_control_reg[IC_WR_DONE_EN])
				|| (host_interrupt_control_reg[IC_RD_DONE]
				&& host_interrupt_control_reg[IC_RD_DONE_EN]);
		end
	end

	// master control: stored bits; reset bits are one-shot actions
	always_ff @(posedge clk) begin
		if (rst) begin
			master_control_status_reg <= RST_WORD;
		end else if (apbWr && paddr == OFF_MCTL) begin
			master_control_status_reg <= RST_WORD;
			master_control_status_reg[MC_WR_PRIO] <= pwdata[MC_WR_PRIO];
			master_control_status_reg[MC_RD_MGMT] <= pwdata[MC_RD_MGMT];
			master_control_status_reg[MC_RD_EN] <= pwdata[MC_RD_EN];
			master_control_status_reg[MC_RD_PRIO] <= pwdata[MC_RD_PRIO];
			master_control_status_reg[MC_WR_MGMT] <= pwdata[MC_WR_MGMT];
			master_control_status_reg[MC_WR_EN] <= pwdata[MC_WR_EN];
		end
	end
	assign flush[0] = apbWr && paddr == OFF_MCTL && pwdata[MC_WRF_RST];
	assign flush[1] = apbWr && paddr == OFF_MCTL && pwdata[MC_RDF_RST];

	// read address and count: software load, else advance per word
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_read_address_reg <= RST_WORD;
			read_byte_counter <= RST_WORD;
		end else begin
			if (apbWr && paddr == OFF_RDADDR) begin
				bus_read_address_reg <= pwdata;
			end else if (rdMove) begin
				bus_read_address_reg <= bus_read_address_reg + WORD_BYTES;
			end
			if (apbWr && paddr == OFF_RDCNT) begin
				read_byte_counter <= pwdata;
			end else if (rdMove) begin
				read_byte_counter <= read_byte_counter - WORD_BYTES;
			end
		end
	end

	// write address and count
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_write_address_reg <= RST_WORD;
			write_byte_counter <= RST_WORD;
		end else begin
			if (apbWr && paddr == OFF_WRADDR) begin
				bus_write_address_reg <= pwdata;
			end else if (wrMove) begin
				bus_write_address_reg <= bus_write_address_reg + WORD_BYTES;
			end
			if (apbWr && paddr == OFF_WRCNT) begin
				write_byte_counter <= pwdata;
			end else if (wrMove) begin
				write_byte_counter <= write_byte_counter - WORD_BYTES;
			end
		end
	end

	// thresholds and request conditions
	assign rdThresh = master_control_status_reg[MC_RD_MGMT]
		? CW'(THR_HIGH) : CW'(THR_LOW);
	assign wrThresh = master_control_status_reg[MC_WR_MGMT]
		? CW'(THR_HIGH) : CW'(THR_LOW);
	assign rdVacant = CW'(DEPTH) - fifoCnt[1];
	assign rdWant = master_control_status_reg[MC_RD_EN]
		&& read_byte_counter != RST_WORD && rdVacant >= rdThresh;
	assign wrWant = master_control_status_reg[MC_WR_EN]
		&& write_byte_counter != RST_WORD && fifoCnt[0] >= wrThresh;

	// bus-master state: pick a direction, stay while words can move
	always_ff @(posedge clk) begin
		if (rst) begin
			bmState <= BM_IDLE;
			lastWasWrite <= 1'b0;
		end else begin
			case (bmState)
				BM_IDLE: begin
					if (rdWant && (!wrWant || lastWasWrite)) begin
						bmState <= BM_READ;
						lastWasWrite <= 1'b0;
					end else if (wrWant) begin
						bmState <= BM_WRITE;
						lastWasWrite <= 1'b1;
					end
				end
				BM_READ: begin
					if (!master_control_status_reg[MC_RD_EN]
						|| read_byte_counter == RST_WORD
						|| fifoCnt[1] == CW'(DEPTH)) begin
						bmState <= BM_IDLE;
					end
				end
				BM_WRITE: begin
					if (!master_control_status_reg[MC_WR_EN]
						|| write_byte_counter == RST_WORD
						|| fifoCnt[0] == '0) begin
						bmState <= BM_IDLE;
					end
				end
				default: bmState <= BM_IDLE;
			endcase
		end
	end
	assign busReq = bmState != BM_IDLE;
	assign busRead = bmState == BM_READ;
	assign busAddr = busRead ? bus_read_address_reg : bus_write_address_reg;
	assign busWrData = fifoOut[0];
	assign rdMove = busRead && busGnt && busRdValid && !flush[1]
		&& fifoCnt[1] != CW'(DEPTH) && read_byte_counter != RST_WORD;
	assign wrMove = bmState == BM_WRITE && busGnt && busWrAccept
		&& !flush[0] && fifoCnt[0] != '0 && write_byte_counter != RST_WORD;

	// fifo hookup: write fifo fed by dsp, read fifo by the bus
	assign fifoPush[0] = dspWrEn && fifoCnt[0] != CW'(DEPTH) && !flush[0];
	assign fifoPop[0] = wrMove;
	assign fifoIn[0] = dspWrData;
	assign fifoPush[1] = rdMove;
	assign fifoPop[1] = dspRdEn && fifoCnt[1] != '0 && !flush[1];
	assign fifoIn[1] = busRdData;
	assign access[0] = dspWrEn;
	assign access[1] = dspRdEn;
	assign avail[0] = fifoCnt[0] != CW'(DEPTH);
	assign avail[1] = fifoCnt[1] != '0;

	// dsp read data register
	always_ff @(posedge clk) begin
		if (rst) begin
			dspRdData <= '0;
		end else if (fifoPop[1]) begin
			dspRdData <= fifoOut[1];
		end
	end

	// pacing enables, written by dsp software only
	always_ff @(posedge clk) begin
		if (rst) begin
			pacingEn <= 2'h0;
		end else if (apbWr && paddr == OFF_FLAG) begin
			pacingEn <= pwdata[FL_RD_PACE:FL_WR_PACE];
		end
	end

	// per-direction fifo and pacing machine
	for (genvar i = 0; i < 2; i++) begin : g_ch
		logic [DATA_W-1:0] mem [DEPTH];
		logic [PW-1:0] wrPtr; // push pointer
		logic [PW-1:0] rdPtr; // pop pointer
		assign fifoOut[i] = mem[rdPtr];

		// storage, written only on push
		always_ff @(posedge clk) begin
			if (fifoPush[i]) begin
				mem[wrPtr] <= fifoIn[i];
			end
		end

		// pointers and count; flag reset empties the fifo
		always_ff @(posedge clk) begin
			if (rst || flush[i]) begin
				wrPtr <= '0;
				rdPtr <= '0;
				fifoCnt[i] <= '0;
			end else begin
				if (fifoPush[i]) begin
					wrPtr <= PW'(wrPtr + 1'b1);
				end
				if (fifoPop[i]) begin
					rdPtr <= PW'(rdPtr + 1'b1);
				end
				if (fifoPush[i] && !fifoPop[i]) begin
					fifoCnt[i] <= fifoCnt[i] + 1'b1;
				end else if (fifoPop[i] && !fifoPush[i]) begin
					fifoCnt[i] <= fifoCnt[i] - 1'b1;
				end
			end
		end

		// pacing: idle until enabled, raise irq when a word can move,
		// drop it on each dsp access and wait for fresh flags
		always_ff @(posedge clk) begin
			if (rst) begin
				paceState[i] <= PC_IDLE;
			end else begin
				case (paceState[i])
					PC_IDLE: begin
						if (pacingEn[i]) begin
							paceState[i] <= PC_ARMED;
						end
					end
					PC_ARMED: begin
						if (!pacingEn[i]) begin
							paceState[i] <= PC_IDLE;
						end else if (avail[i] && !access[i]) begin
							paceState[i] <= PC_ACTIVE;
						end
					end
					PC_ACTIVE: begin
						if (!pacingEn[i]) begin
							paceState[i] <= PC_IDLE;
						end else if (access[i]) begin
							paceState[i] <= PC_ARMED;
						end
					end
					default: paceState[i] <= PC_IDLE;
				endcase
			end
		end
		assign paceIrq[i] = paceState[i] == PC_ACTIVE;
	end
	assign write_fifo_dsp_interrupt = paceIrq[0];
	assign read_fifo_dsp_interrupt = paceIrq[1];

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence rdReady_s;
		pacingEn[1] && avail[1] && !access[1];
	endsequence

	host_rd_irq_a: assert property (
		rdMove && read_byte_counter == WORD_BYTES
		&& host_interrupt_control_reg[IC_RD_DONE_EN] |-> ##2 hostIrq)
		else $error("read end did not raise host irq");
	fifo_flush_a: assert property (flush[1] |=> fifoCnt[1] == '0)
		else $error("read fifo not empty after flag reset");
	rd_thresh_a: assert property (
		$rose(bmState == BM_READ) |-> $past(rdVacant >= rdThresh))
		else $error("read request below vacancy threshold");
	wr_thresh_a: assert property (
		$rose(bmState == BM_WRITE) |-> $past(fifoCnt[0] >= wrThresh))
		else $error("write request below fill threshold");
	bm_enable_a: assert property (
		!master_control_status_reg[MC_RD_EN] && bmState != BM_READ
		|=> bmState != BM_READ)
		else $error("read request without enable");
	host_only_a: assert property (
		$rose(master_control_status_reg[MC_WR_EN])
		|-> $past(apbWr && paddr == OFF_MCTL))
		else $error("write master enabled without host write");
	rd_pace_a: assert property (
		rdReady_s [*2] |=> read_fifo_dsp_interrupt)
		else $error("read pacing irq missing");
	wr_pace_off_a: assert property (
		!pacingEn[0] |=> ##1 !write_fifo_dsp_interrupt)
		else $error("write pacing irq while disabled");
	pace_drop_a: assert property (
		read_fifo_dsp_interrupt && access[1]
		|=> !read_fifo_dsp_interrupt)
		else $error("read pacing irq held after access");
endmodule

// >>> pbm_pkg.sv
// constants and types for the bus-master fifo control block
// assumes one clock domain and an apb register port
package pbm_pkg;
	localparam int ADDR_W = 8; // apb byte address width
	localparam int DATA_W = 32; // apb and fifo word width
	localparam int FIFO_DEPTH = 8; // words per fifo
	// register byte offsets
	localparam logic [7:0] OFF_INTCTL = 8'h00; // host_interrupt_control_reg
	localparam logic [7:0] OFF_MCTL = 8'h04; // master_control_status_reg
	localparam logic [7:0] OFF_RDADDR = 8'h08; // bus_read_address_reg
	localparam logic [7:0] OFF_WRADDR = 8'h0c; // bus_write_address_reg
	localparam logic [7:0] OFF_WRCNT = 8'h10; // write_byte_counter
	localparam logic [7:0] OFF_RDCNT = 8'h14; // read_byte_counter
	localparam logic [7:0] OFF_FLAG = 8'h18; // fifo_flag_control_reg
	// host interrupt control fields
	localparam int IC_WR_DONE_EN = 14; // write end irq enable
	localparam int IC_RD_DONE_EN = 15; // read end irq enable
	localparam int IC_WR_DONE = 16; // write end status, write 1 clears
	localparam int IC_RD_DONE = 17; // read end status, write 1 clears
	// master control fields
	localparam int MC_WR_PRIO = 8; // write priority
	localparam int MC_RD_MGMT = 9; // read: 1 = four vacant
	localparam int MC_RD_EN = 10; // read bus-master enable
	localparam int MC_RD_PRIO = 12; // read priority
	localparam int MC_WR_MGMT = 13; // write: 1 = four filled
	localparam int MC_WR_EN = 14; // write bus-master enable
	localparam int MC_WRF_RST = 25; // write fifo flag reset, action bit
	localparam int MC_RDF_RST = 26; // read fifo flag reset, action bit
	// flag control fields
	localparam int FL_WR_PACE = 0; // write_pacing_irq_enable
	localparam int FL_RD_PACE = 1; // read_pacing_irq_enable
	localparam int FL_RD_EMPTY = 2; // read fifo empty, read only
	localparam int FL_WR_FULL = 3; // write fifo full, read only
	localparam int FL_RD_IRQ = 4; // read pacing irq level, read only
	localparam int FL_WR_IRQ = 5; // write pacing irq level, read only
	// reset values and counts
	localparam logic [31:0] RST_WORD = 32'h0; // every register but fifo_flag_control_reg resets here
	localparam logic [31:0] WORD_BYTES = 32'h4; // bytes per transfer
	localparam int THR_LOW = 1; // one word threshold
	localparam int THR_HIGH = 4; // four word threshold
	typedef enum logic [1:0] {
		BM_IDLE = 2'b00,
		BM_READ = 2'b01,
		BM_WRITE = 2'b10
	} pbm_bm_state_t;
	typedef enum logic [1:0] {
		PC_IDLE = 2'b00,
		PC_ARMED = 2'b01,
		PC_ACTIVE = 2'b10
	} pbm_pace_state_t;
endpackage

// >>> pbm_host_model.sv
// pci host memory model for the bus-master side of pbm_fifo_ctrl
// assumes requests and grants are sampled on rising edges of clk
`timescale 1ns/1ps
module pbm_host_model (
	input wire logic clk, // bus clock
	input wire logic rst, // synchronous, active high
	input wire logic slow, // 1 = answer only every other cycle
	input wire logic busReq, // master wants the bus
	input wire logic busRead, // 1 = host memory to read fifo
	input wire logic [31:0] busAddr, // address from master
	input wire logic [31:0] busWrData, // word offered by master
	output logic busGnt, // grant level
	output logic busRdValid, // host word valid
	output logic [31:0] busRdData, // host word
	output logic busWrAccept // host took the word
);
	logic tick; // stall phase
	logic go; // may answer this cycle
	logic [31:0] mem [0:63]; // captured write words by word index
	assign go = busReq && (!slow || tick);
	// handshakes; a gap cycle follows every answer so that the address
	// has settled before the next word is offered
	always_ff @(posedge clk) begin
		if (rst) begin
			tick <= 1'b0;
			busGnt <= 1'b0;
			busRdValid <= 1'b0;
			busWrAccept <= 1'b0;
			busRdData <= 32'h0;
		end else begin
			tick <= ~tick;
			busGnt <= go;
			busRdValid <= go && busRead && !busRdValid;
			busWrAccept <= go && !busRead && !busWrAccept;
			// host word is a pattern of its aligned address
			if (go && busRead && !busRdValid) begin
				busRdData <= {busAddr[31:2], 2'b00} ^ 32'h5a5a0000;
			end else begin
				busRdData <= ~busRdData; // no stale word outside valid
			end
			// store by word index, whole 32-bit words only
			if (busReq && busGnt && busWrAccept && !busRead) begin
				mem[busAddr[7:2]] <= busWrData;
			end
		end
	end
endmodule

// >>> pbm_fifo_ctrl_tb_top.sv
// testbench: apb host tasks, dsp strobe tasks, read and write transfers
// assumes pbm_pkg, pbm_fifo_ctrl and pbm_host_model compiled first
`timescale 1ns/1ps
module pbm_fifo_ctrl_tb_top;
	import pbm_pkg::*;
	localparam logic [31:0] PRI = (32'h1 << MC_WR_PRIO) | (32'h1 << MC_RD_PRIO);
	logic clk, rst, psel, penable, pwrite, slow, err; // bench side
	logic [7:0] paddr; // apb address
	logic [31:0] pwdata, prdata, rd, busAddr, busRdData, busWrData;
	logic [31:0] dspRdData, dspWrData; // dsp words
	logic [31:0] dspMem [16]; // dsp-side destination of read words
	logic [1:0] dmaStart; // dsp dma start field
	logic pready, pslverr, busReq, busGnt, busRead, busRdValid, busWrAccept;
	logic hostIrq, dspRdEn, dspWrEn, rdIrq, wrIrq; // design irq outputs and dsp strobes
	int errorCnt = 0;
	int nTests = 0;
	pbm_fifo_ctrl pbm_fifo_ctrl_inst (.clk, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .busReq, .busGnt,
		.busRead, .busAddr, .busRdValid, .busRdData, .busWrData,
		.busWrAccept, .hostIrq, .dspRdEn, .dspRdData, .dspWrEn, .dspWrData,
		.read_fifo_dsp_interrupt(rdIrq), .write_fifo_dsp_interrupt(wrIrq));
	pbm_host_model pbm_host_model_inst (.clk, .rst, .slow, .busReq,
		.busRead, .busAddr, .busWrData, .busGnt, .busRdValid, .busRdData,
		.busWrAccept);
	// free running clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// compare and count
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		nTests++;
		if (s !== e) begin
			errorCnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one apb transfer; read data and error kept in rd and err
	task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// let n edges pass, then sample settled outputs
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	function logic sig(input int s);
		case (s)
			0: return rdIrq;
			1: return wrIrq;
			default: return hostIrq;
		endcase
	endfunction
	// bounded wait for an interrupt level
	task waitOn(input int s);
		int n;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (sig(s) !== 1'b1 && n < 400);
		chk("irq wait", 32'(sig(s)), 32'h1);
	endtask
	// dsp strobes at the dedicated fifo address, one word each
	task pop(output logic [31:0] v);
		@(posedge clk);
		dspRdEn <= 1'b1;
		@(posedge clk);
		dspRdEn <= 1'b0;
		#1 v = dspRdData;
	endtask
	task push(input logic [31:0] v);
		@(posedge clk);
		dspWrEn <= 1'b1;
		dspWrData <= v;
		@(posedge clk);
		dspWrEn <= 1'b0;
		dspWrData <= ~v; // released data is not held
	endtask
	task results;
		$display("checks %0d mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		#300000;
		errorCnt++;
		results;
	end
	// main sequence
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, slow, dspRdEn, dspWrEn} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		dspWrData = 32'h0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// reset values and unmapped address
		for (int a = 0; a < 6; a++) begin
			apb(1'b0, 8'(a * 4), 32'h0);
			chk("reg reset", rd, RST_WORD);
		end
		apb(1'b0, OFF_FLAG, 32'h0);
		chk("flag reset", rd, 32'h4);
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped err", 32'(err), 32'h1);
		chk("unmapped data", rd, 32'h0);
		chk("pready", 32'(pready), 32'h1);
		$display("test reset done");
		// read transfer of 16 words, four-vacant threshold
		apb(1'b1, OFF_INTCTL, 32'h1 << IC_RD_DONE_EN);
		apb(1'b1, OFF_MCTL, (32'h1 << MC_RDF_RST) | (32'h1 << MC_WRF_RST));
		apb(1'b1, OFF_RDADDR, 32'h100);
		apb(1'b1, OFF_RDCNT, 32'd64);
		cyc(5);
		chk("req idle", 32'(busReq), 32'h0);
		apb(1'b1, OFF_MCTL, PRI | (32'h1 << MC_RD_MGMT) | (32'h1 << MC_RD_EN));
		cyc(40);
		chk("req full", 32'(busReq), 32'h0);
		chk("rd irq off", 32'(rdIrq), 32'h0);
		apb(1'b0, OFF_RDCNT, 32'h0);
		chk("rd count", rd, 32'd32);
		apb(1'b1, OFF_FLAG, 32'h1 << FL_RD_PACE);
		dmaStart = 2'b01;
		// 16 dsp words against 64 host bytes
		for (int i = 0; i < 16 && dmaStart == 2'b01; i++) begin
			waitOn(0);
			pop(dspMem[i]);
			chk("rd word", dspMem[i], (32'h100 + 32'(4 * i)) ^ 32'h5a5a0000);
			if (i == 0) begin
				cyc(3);
				chk("req one vacant", 32'(busReq), 32'h0);
			end
		end
		waitOn(2);
		apb(1'b0, OFF_INTCTL, 32'h0);
		chk("rd done", rd, (32'h1 << IC_RD_DONE_EN) | (32'h1 << IC_RD_DONE));
		apb(1'b0, OFF_RDADDR, 32'h0);
		chk("rd addr", rd, 32'h140);
		apb(1'b1, OFF_INTCTL, 32'h1 << IC_RD_DONE);
		cyc(3);
		chk("host irq clr", 32'(hostIrq), 32'h0);
		chk("rd irq empty", 32'(rdIrq), 32'h0);
		$display("test read done");
		// two more words with end irq gated off, then flag reset
		apb(1'b1, OFF_RDCNT, 32'd8);
		cyc(20);
		apb(1'b0, OFF_FLAG, 32'h0);
		chk("rd not empty", 32'(rd[FL_RD_EMPTY]), 32'h0);
		chk("irq gated", 32'(hostIrq), 32'h0);
		apb(1'b0, OFF_INTCTL, 32'h0);
		chk("done ungated", rd, 32'h1 << IC_RD_DONE);
		apb(1'b1, OFF_MCTL, 32'h1 << MC_RDF_RST);
		apb(1'b1, OFF_FLAG, 32'h0);
		apb(1'b0, OFF_FLAG, 32'h0);
		chk("flags after reset", rd, 32'h4);
		chk("rd irq idle", 32'(rdIrq), 32'h0);
		apb(1'b1, OFF_INTCTL, 32'h1 << IC_RD_DONE);
		$display("test flag reset done");
		// write transfer of 8 words, four-filled threshold, slow host
		slow <= 1'b1;
		apb(1'b1, OFF_INTCTL, 32'h1 << IC_WR_DONE_EN);
		apb(1'b1, OFF_WRADDR, 32'h200);
		apb(1'b1, OFF_WRCNT, 32'd32);
		apb(1'b1, OFF_MCTL, PRI | (32'h1 << MC_WR_MGMT) | (32'h1 << MC_WR_EN));
		cyc(3);
		chk("wr irq off", 32'(wrIrq), 32'h0);
		apb(1'b1, OFF_FLAG, 32'h1 << FL_WR_PACE);
		dmaStart = 2'b01;
		// 8 dsp words against 32 host bytes
		for (int i = 0; i < 8 && dmaStart == 2'b01; i++) begin
			waitOn(1);
			push(32'hc0de0000 + 32'(i));
			if (i == 2) begin
				cyc(4);
				chk("req three filled", 32'(busReq), 32'h0);
			end
		end
		waitOn(2);
		for (int i = 0; i < 8; i++) begin
			chk("host word", pbm_host_model_inst.mem[i], 32'hc0de0000 + 32'(i));
		end
		apb(1'b0, OFF_INTCTL, 32'h0);
		chk("wr done", rd, (32'h1 << IC_WR_DONE_EN) | (32'h1 << IC_WR_DONE));
		apb(1'b0, OFF_WRCNT, 32'h0);
		chk("wr count", rd, 32'h0);
		apb(1'b1, OFF_FLAG, 32'h0);
		cyc(3);
		chk("wr irq idle", 32'(wrIrq), 32'h0);
		$display("test write done");
		results;
	end
endmodule
